// *** src/lhp_consts.svh ***
`ifndef LHP_CONSTS_SVH
`define LHP_CONSTS_SVH

// Clock and timing.
`define LHP_CLK_MHZ      250
`define LHP_BUSY_NS      40000
`define LHP_BUSY_CYC     ((`LHP_BUSY_NS * `LHP_CLK_MHZ) / 1000)
`define LHP_POR_CYC      2'h3
`define LHP_FRAME_DIV    12'hc00
`define LHP_BUSY_W       14

// Memory sizes and address map.
`define LHP_DD_SIZE      80
`define LHP_CG_SIZE      64
`define LHP_LINE2_BASE   7'h40
`define LHP_END_1X24     7'h4f
`define LHP_END_L1       7'h27
`define LHP_END_L2       7'h67
`define LHP_L2_IDX_OFS   7'h28
`define LHP_LEN_1X24     7'h50
`define LHP_LEN_LINE     7'h28
`define LHP_CLEAR_CODE   8'h20

// Supply voltage scale in millivolts.
`define LHP_VSTEP_MV     13'h050
`define LHP_VBASE_MV     13'h71c

// Command codes and field positions.
`define LHP_CMD_CLEAR    8'h01
`define LHP_BIT_ID       1
`define LHP_BIT_DISP     2
`define LHP_BIT_SC       3
`define LHP_BIT_RL       2
`define LHP_BIT_DL       4
`define LHP_BIT_M        2
`define LHP_BIT_SL       1
`define LHP_BIT_H        0
`define LHP_BIT_ICON     1
`define LHP_BIT_DIRECT   0
`define LHP_BIT_VSEL     6

// Bias level counts.
`define LHP_BIAS_5       3'h5
`define LHP_BIAS_4       3'h4

`endif

// *** src/lhp_pkg.sv ***
package lhp_pkg;

  typedef enum logic [1:0] {LHP_1X24, LHP_2X12, LHP_1X12} lhp_line_t;

  typedef enum logic [1:0] {LHP_MUX_18, LHP_MUX_9, LHP_MUX_2} lhp_mux_t;

  typedef struct packed {
    logic       e;
    logic       rs;
    logic       rw;
    logic [7:0] db;
  } lhp_pins_t;

  typedef struct packed {
    logic        gen_on;
    logic        bypass;
    logic [5:0]  code;
    logic [12:0] vop_mv;
    lhp_mux_t    mux;
    logic [2:0]  bias_levels;
  } lhp_supply_t;

endpackage

// *** src/lhp_pin_sync.sv ***
`timescale 1ns/10ps
// Three-stage pin synchroniser; a bit moves on only when stages two and
// three agree, so a single-cycle glitch never reaches the core.
module lhp_pin_sync #(
  parameter int W = 11
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o  <= '0;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
        begin
          q_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

// *** src/lhp_host_port.sv ***
`timescale 1ns/10ps
`include "lhp_consts.svh"
// Function
// - Two 6-bit supply voltage setting registers.
// - Voltage equals code times 0.08 plus 1.82.
// - Zero code in active mode stops generator.
// - Bypass bit disables generator, feeds supply.
// - Bias levels follow multiplex rate automatically.
// - Frame tick is clock divided by 3072.
// - Power-on reset takes three clock cycles.
// - Select line picks command or data register.
// - Command register is write-only.
// - Data register preloaded from RAM before reads.
// - Busy flag set; instructions ignored meanwhile.
// - Status read puts busy on top line.
// - Status read puts pointer on low lines.
// - Pointer loaded by commands, steps per access.
// - Display RAM holds 80 codes, only the first 40 usable in 1x12 mode.
// - Line one shows first 24 locations unshifted.
// - Valid display address space per line mode.
// - Access wrap moves pointer to next line in 2x12 mode, back to address 0 in one-line modes.
// - Display shift wraps within each line.
// - Four-bit bus splits bytes, upper lines.
module lhp_host_port #(
  parameter int unsigned BUSY_CYC = `LHP_BUSY_CYC
) (
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  input  wire logic          e_i,
  input  wire logic          rs_i,
  input  wire logic          rw_i,
  input  wire logic [7:0]    db_i,
  output logic      [7:0]    db_o,
  output logic               db_oe_o,
  output lhp_pkg::lhp_supply_t supply_o,
  output logic               frame_tick_o,
  output logic      [6:0]    disp_start_o,
  output logic               disp_on_o,
  output logic               busy_o
);
  import lhp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  lhp_pins_t             pin_raw;
  lhp_pins_t             pin_s;
  logic                  e_q_r;
  logic [1:0]            por_cnt_r;
  logic                  por_done;
  logic                  bus8_r;
  logic                  nib_r;
  logic [3:0]            hi_r;
  logic                  id_r;
  logic                  two_r;
  logic                  half_r;
  logic                  ext_r;
  logic                  icon_r;
  logic                  direct_r;
  logic [5:0]            va_r;
  logic [5:0]            vb_r;
  logic [6:0]            ac_r;
  logic                  sel_cg_r;
  logic [7:0]            dr_r;
  logic                  pf_r;
  logic                  clr_act_r;
  logic [6:0]            clr_idx_r;
  logic [`LHP_BUSY_W-1:0] busy_cnt_r;
  logic [11:0]           fr_cnt_r;
  logic [7:0]            display_ram [0:`LHP_DD_SIZE-1];
  logic [7:0]            glyph_ram   [0:`LHP_CG_SIZE-1];

  logic                  e_rise;
  logic                  e_fall;
  logic                  busy;
  logic                  xfer_done;
  logic [7:0]            wr_byte;
  logic                  cmd_go;
  logic                  dat_wr;
  logic                  dat_rd;
  lhp_line_t             line_mode;
  logic [6:0]            line_len;
  logic                  dd_ok;
  logic [6:0]            dd_idx;
  logic [7:0]            rd_word;
  logic [5:0]            act_code;

  //////////////////////////////////////////////////////////////////////////
  // Pin capture and power-on sequencing.
  assign pin_raw = lhp_pins_t'({e_i, rs_i, rw_i, db_i});

  lhp_pin_sync #(
    .W ($bits(lhp_pins_t))
  ) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .d_i      (pin_raw),
    .q_o      (pin_s)
  );

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      por_cnt_r <= 2'h0;
    else if (por_cnt_r != `LHP_POR_CYC)
      por_cnt_r <= por_cnt_r + 2'h1;
  end

  assign por_done = (por_cnt_r == `LHP_POR_CYC);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      e_q_r <= 1'b0;
    else
      e_q_r <= pin_s.e;
  end

  assign e_rise = pin_s.e & ~e_q_r;
  assign e_fall = ~pin_s.e & e_q_r;

  assign busy      = ~por_done | clr_act_r | (busy_cnt_r != '0);
  assign xfer_done = e_fall & (bus8_r | nib_r);
  assign wr_byte   = bus8_r ? pin_s.db : {hi_r, pin_s.db[7:4]};
  assign cmd_go    = xfer_done & ~pin_s.rs & ~pin_s.rw & ~busy;
  assign dat_wr    = xfer_done & pin_s.rs & ~pin_s.rw & ~busy;
  assign dat_rd    = xfer_done & pin_s.rs & pin_s.rw & ~busy;

  //////////////////////////////////////////////////////////////////////////
  // Line mode and display RAM address mapping.
  assign line_mode = two_r ? LHP_2X12 : (half_r ? LHP_1X12 : LHP_1X24);
  assign line_len  = (line_mode == LHP_1X24) ? `LHP_LEN_1X24 : `LHP_LEN_LINE;

  always_comb
  begin
    dd_ok  = 1'b0;
    dd_idx = ac_r;
    unique case (line_mode)
      LHP_1X24: dd_ok = (ac_r <= `LHP_END_1X24);
      LHP_1X12: dd_ok = (ac_r <= `LHP_END_L1);
      LHP_2X12:
      begin
        if (ac_r <= `LHP_END_L1)
          dd_ok = 1'b1;
        else if (ac_r >= `LHP_LINE2_BASE && ac_r <= `LHP_END_L2)
        begin
          dd_ok  = 1'b1;
          dd_idx = ac_r - `LHP_LINE2_BASE + `LHP_L2_IDX_OFS;
        end
      end
    endcase
  end

  function automatic logic [6:0] ac_step(input logic [6:0] a,
                                         input logic      up,
                                         input logic      cg,
                                         input lhp_line_t m);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (cg)
      r = {1'b0, r[5:0]};
    else
    begin
      unique case (m)
        LHP_1X24:
          if (up && a == `LHP_END_1X24)
            r = 7'h00;
          else if (!up && a == 7'h00)
            r = `LHP_END_1X24;
        LHP_1X12:
          if (up && a == `LHP_END_L1)
            r = 7'h00;
          else if (!up && a == 7'h00)
            r = `LHP_END_L1;
        LHP_2X12:
          if (up && a == `LHP_END_L1)
            r = `LHP_LINE2_BASE;
          else if (up && a == `LHP_END_L2)
            r = 7'h00;
          else if (!up && a == `LHP_LINE2_BASE)
            r = `LHP_END_L1;
          else if (!up && a == 7'h00)
            r = `LHP_END_L2;
      endcase
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Configuration set by instructions.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i || !por_done)
    begin
      bus8_r    <= 1'b1;
      id_r      <= 1'b1;
      two_r     <= 1'b0;
      half_r    <= 1'b0;
      ext_r     <= 1'b0;
      icon_r    <= 1'b0;
      direct_r  <= 1'b0;
      va_r      <= 6'h00;
      vb_r      <= 6'h00;
      disp_on_o <= 1'b0;
    end
    else if (cmd_go)
    begin
      if (wr_byte == `LHP_CMD_CLEAR)
        id_r <= 1'b1;
      else if (wr_byte[7:5] == 3'b001)
      begin
        bus8_r <= wr_byte[`LHP_BIT_DL];
        two_r  <= wr_byte[`LHP_BIT_M];
        half_r <= wr_byte[`LHP_BIT_SL];
        ext_r  <= wr_byte[`LHP_BIT_H];
      end
      else if (ext_r && wr_byte[7])
      begin
        if (wr_byte[`LHP_BIT_VSEL])
          vb_r <= wr_byte[5:0];
        else
          va_r <= wr_byte[5:0];
      end
      else if (ext_r && wr_byte[7:2] == 6'h01)
      begin
        icon_r   <= wr_byte[`LHP_BIT_ICON];
        direct_r <= wr_byte[`LHP_BIT_DIRECT];
      end
      else if (!ext_r && wr_byte[7:2] == 6'h01)
        id_r <= wr_byte[`LHP_BIT_ID];
      else if (!ext_r && wr_byte[7:3] == 5'h01)
        disp_on_o <= wr_byte[`LHP_BIT_DISP];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address pointer and display shift.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i || !por_done)
    begin
      ac_r         <= 7'h00;
      sel_cg_r     <= 1'b0;
      disp_start_o <= 7'h00;
    end
    else if (cmd_go)
    begin
      if (wr_byte[7:1] == 7'h00)
      begin
        ac_r         <= 7'h00;
        sel_cg_r     <= 1'b0;
        disp_start_o <= 7'h00;
      end
      else if (wr_byte[7:5] == 3'b001)
        disp_start_o <= 7'h00;
      else if (!ext_r && wr_byte[7:4] == 4'h1)
      begin
        if (!wr_byte[`LHP_BIT_SC])
          ac_r <= ac_step(ac_r, wr_byte[`LHP_BIT_RL], sel_cg_r, line_mode);
        else if (wr_byte[`LHP_BIT_RL])
          disp_start_o <= (disp_start_o == line_len - 7'h01) ?
                          7'h00 : disp_start_o + 7'h01;
        else
          disp_start_o <= (disp_start_o == 7'h00) ?
                          line_len - 7'h01 : disp_start_o - 7'h01;
      end
      else if (!ext_r && wr_byte[7:6] == 2'b01)
      begin
        ac_r     <= {1'b0, wr_byte[5:0]};
        sel_cg_r <= 1'b1;
      end
      else if (!ext_r && wr_byte[7])
      begin
        ac_r     <= wr_byte[6:0];
        sel_cg_r <= 1'b0;
      end
    end
    else if (dat_wr || dat_rd)
      ac_r <= ac_step(ac_r, id_r, sel_cg_r, line_mode);
  end

  //////////////////////////////////////////////////////////////////////////
  // Busy timer and clear engine.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i || !por_done)
    begin
      busy_cnt_r <= '0;
      clr_act_r  <= 1'b0;
      clr_idx_r  <= 7'h00;
      busy_o     <= 1'b1;
    end
    else
    begin
      busy_o <= busy;
      if (cmd_go || dat_wr || dat_rd)
        busy_cnt_r <= `LHP_BUSY_W'(BUSY_CYC - 1);
      else if (busy_cnt_r != '0)
        busy_cnt_r <= busy_cnt_r - 1'b1;
      if (cmd_go && wr_byte == `LHP_CMD_CLEAR)
      begin
        clr_act_r <= 1'b1;
        clr_idx_r <= 7'h00;
      end
      else if (clr_act_r)
      begin
        clr_idx_r <= clr_idx_r + 7'h01;
        if (clr_idx_r == 7'(`LHP_DD_SIZE - 1))
          clr_act_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // RAM arrays; every display location valid in the line mode is plain storage when not shown.
  // eighty stored codes
  always_ff @(posedge mclk_i)
  begin
    if (clr_act_r)
      display_ram[clr_idx_r] <= `LHP_CLEAR_CODE;
    else if (dat_wr && sel_cg_r)
      glyph_ram[ac_r[5:0]] <= wr_byte;
    else if (dat_wr && dd_ok)
      display_ram[dd_idx] <= wr_byte;
  end

  // The prefetch lands one cycle after the pointer moves, well before the
  // next enable edge can survive the pin synchroniser.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pf_r <= 1'b0;
      dr_r <= 8'h00;
    end
    else
    begin
      pf_r <= cmd_go | dat_wr | dat_rd | clr_act_r;
      if (pf_r)
      begin
        if (sel_cg_r)
          dr_r <= glyph_ram[ac_r[5:0]];
        else if (dd_ok)
          dr_r <= display_ram[dd_idx];
        else
          dr_r <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus transfer and read drive.
  // command register never read
  assign rd_word = pin_s.rs ? dr_r : {busy, ac_r};

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      nib_r   <= 1'b0;
      hi_r    <= 4'h0;
      db_o    <= 8'h00;
      db_oe_o <= 1'b0;
    end
    else
    begin
      if (!bus8_r && e_fall)
      begin
        nib_r <= ~nib_r;
        hi_r  <= pin_s.db[7:4];
      end
      else if (bus8_r)
        nib_r <= 1'b0;
      if (e_rise && pin_s.rw)
      begin
        db_oe_o <= 1'b1;
        if (bus8_r)
          db_o <= rd_word;
        else
          db_o <= {nib_r ? rd_word[3:0] : rd_word[7:4], 4'h0};
      end
      else if (e_fall || !pin_s.rw)
        db_oe_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Supply control and frame timing.
  assign act_code = icon_r ? vb_r : va_r;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      supply_o <= '0;
    else
    begin
      supply_o.gen_on <= ~direct_r & (act_code != 6'h00);
      supply_o.bypass <= direct_r;
      supply_o.code   <= act_code;
      if (!direct_r && act_code != 6'h00)
        supply_o.vop_mv <= {7'h00, act_code} * `LHP_VSTEP_MV
                           + `LHP_VBASE_MV;
      else
        supply_o.vop_mv <= 13'h0000;
      if (icon_r)
      begin
        supply_o.mux         <= LHP_MUX_2;
        supply_o.bias_levels <= `LHP_BIAS_4;
      end
      else
      begin
        supply_o.mux         <= two_r ? LHP_MUX_18 : LHP_MUX_9;
        supply_o.bias_levels <= `LHP_BIAS_5;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i || !por_done)
    begin
      fr_cnt_r     <= 12'h000;
      frame_tick_o <= 1'b0;
    end
    else if (fr_cnt_r == `LHP_FRAME_DIV - 12'h001)
    begin
      fr_cnt_r     <= 12'h000;
      frame_tick_o <= 1'b1;
    end
    else
    begin
      fr_cnt_r     <= fr_cnt_r + 12'h001;
      frame_tick_o <= 1'b0;
    end
  end

endmodule

// *** dv/lhp_host_port_props.sv ***
`timescale 1ns/10ps
module lhp_host_port_props #(
  parameter int unsigned BUSY_CYC = 10000
) (
  input  wire logic                 mclk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 e_i,
  input  wire logic                 rs_i,
  input  wire logic                 rw_i,
  input  wire logic [7:0]           db_o,
  input  wire logic                 db_oe_o,
  input  wire lhp_pkg::lhp_supply_t supply_o,
  input  wire logic                 frame_tick_o,
  input  wire logic                 busy_o
);
  import lhp_pkg::*;

  logic [1:0]  age_r;
  logic [11:0] cnt_r;
  logic        seen_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs read as reset values until the first edges after release.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end

  // The first tick after reset is only a start mark, not a measured period.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_r  <= 12'h000;
      seen_r <= 1'b0;
    end
    else if (frame_tick_o)
    begin
      cnt_r  <= 12'h000;
      seen_r <= 1'b1;
    end
    else
      cnt_r <= cnt_r + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_write_held;
    (e_i && !rw_i) [*8];
  endsequence

  sequence s_status_start;
    $rose(db_oe_o) && !rs_i && $stable(busy_o);
  endsequence

  a_read_drive_only: assert property (
    $rose(db_oe_o) |-> (e_i && rw_i)) else $error("bus driven outside read");
  a_write_no_drive: assert property (
    s_write_held |-> !db_oe_o) else $error("bus driven during write");
  a_status_busy_bit: assert property (
    s_status_start |-> db_o[7] == busy_o) else $error("busy bit wrong");
  a_drive_release: assert property (
    $fell(e_i) |-> ##[1:8] !db_oe_o) else $error("bus not released");
  a_por_busy: assert property (
    age_r != 2'h3 |-> busy_o) else $error("busy low during power-on");
  a_frame_period: assert property (
    frame_tick_o && seen_r |-> cnt_r == 12'hbff) else $error("frame period");
  a_tick_single: assert property (
    frame_tick_o |=> !frame_tick_o) else $error("frame tick too long");
  a_bias_follow: assert property (
    age_r == 2'h3 |-> supply_o.bias_levels ==
      ((supply_o.mux == LHP_MUX_2) ? 3'h4 : 3'h5)) else $error("bias levels");
  a_vop_value: assert property (
    age_r == 2'h3 |-> supply_o.vop_mv == (supply_o.gen_on ?
      13'(supply_o.code) * 13'h050 + 13'h71c : 13'h000))
    else $error("supply voltage value");
  a_gen_cut_off: assert property (
    supply_o.gen_on |-> supply_o.code != 6'h00 && !supply_o.bypass)
    else $error("generator on while it must be off");
endmodule

bind lhp_host_port lhp_host_port_props #(.BUSY_CYC(BUSY_CYC)) u_props (
  .mclk_i       (mclk_i),
  .resetn_i     (resetn_i),
  .e_i          (e_i),
  .rs_i         (rs_i),
  .rw_i         (rw_i),
  .db_o         (db_o),
  .db_oe_o      (db_oe_o),
  .supply_o     (supply_o),
  .frame_tick_o (frame_tick_o),
  .busy_o       (busy_o)
);

// *** dv/lhp_host_model.sv ***
`timescale 1ns/10ps
module lhp_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] bus_i,
  output logic            e_o,
  output logic            rs_o,
  output logic            rw_o,
  output logic [7:0]      db_o,
  output logic            db_oe_o
);
  initial
  begin
    e_o     = 1'b0;
    rs_o    = 1'b0;
    rw_o    = 1'b1;
    db_o    = 8'h00;
    db_oe_o = 1'b0;
  end

  // enable strobed transfer
  // Select, direction and data stay put well past the fall of the strobe,
  // because the device only sees the fall after its pin synchroniser.
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(negedge mclk_i);
    rs_o    = rs;
    rw_o    = rw;
    db_o    = wd;
    db_oe_o = !rw;
    e_o     = 1'b1;
    repeat (9) @(negedge mclk_i);
    rd  = bus_i;
    e_o = 1'b0;
    repeat (8) @(negedge mclk_i);
    db_oe_o = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask

  task automatic wait_ready(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule

// *** dv/lhp_host_port_tb.sv ***
`timescale 1ns/10ps
module lhp_host_port_tb;
  import lhp_pkg::*;

  logic        mclk_i;
  logic        resetn_i;
  logic        e;
  logic        rs;
  logic        rw;
  logic        host_oe;
  logic        dut_oe;
  logic        tick;
  logic        on;
  logic        busy;
  logic [7:0]  host_db;
  logic [7:0]  dut_db;
  logic [7:0]  bus;
  logic [7:0]  idle_pat = 8'h55;
  logic [6:0]  start;
  lhp_supply_t sup;
  int          n_mismatch;
  int          samples_checked;

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // An undriven bus must not look like stale data, so it toggles.
  always @(posedge mclk_i) idle_pat <= ~idle_pat;
  assign bus = dut_oe ? dut_db : (host_oe ? host_db : idle_pat);

  lhp_host_port #(.BUSY_CYC(60)) u_dut (
    .mclk_i (mclk_i), .resetn_i (resetn_i), .e_i (e), .rs_i (rs),
    .rw_i (rw), .db_i (bus), .db_o (dut_db), .db_oe_o (dut_oe),
    .supply_o (sup), .frame_tick_o (tick), .disp_start_o (start),
    .disp_on_o (on), .busy_o (busy));

  lhp_host_model u_host (
    .mclk_i (mclk_i), .bus_i (bus), .e_o (e), .rs_o (rs), .rw_o (rw),
    .db_o (host_db), .db_oe_o (host_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic ready;
    logic ok;
    u_host.wait_ready(ok);
    chk_val({15'h0000, ok}, 16'h0001);
  endtask

  task automatic cmd(input logic [7:0] c);
    logic [7:0] r;
    ready();
    u_host.xfer(1'b0, 1'b0, c, r);
  endtask

  task automatic wdat(input logic [7:0] d);
    logic [7:0] r;
    ready();
    u_host.xfer(1'b1, 1'b0, d, r);
  endtask

  task automatic rdat(output logic [7:0] d);
    ready();
    u_host.xfer(1'b1, 1'b1, 8'h00, d);
  endtask

  task automatic ac_is(input logic [6:0] a);
    logic [7:0] s;
    ready();
    u_host.xfer(1'b0, 1'b1, 8'h00, s);
    chk_val({8'h00, s}, {9'h000, a});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge mclk_i);
    chk_val({15'h0000, busy}, 16'h0001);
    chk_val({15'h0000, sup.gen_on}, 16'h0000);
    ac_is(7'h00);
    $display("test reset done");
  endtask

  task automatic t_wrap;
    logic [7:0] fs [4] = '{8'h30, 8'h34, 8'h34, 8'h32};
    logic [6:0] at [4] = '{7'h4f, 7'h27, 7'h67, 7'h27};
    logic [6:0] nx [4] = '{7'h00, 7'h40, 7'h00, 7'h00};
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      cmd(fs[i]);
      cmd({1'b1, at[i]});
      wdat(8'hc0 + 8'(i));
      ac_is(nx[i]);
      cmd({1'b1, at[i]});
      rdat(d);
      chk_val({8'h00, d}, {8'h00, 8'hc0 + 8'(i)});
      ac_is(nx[i]);
    end
    cmd(8'hb0);
    wdat(8'h5a);
    cmd(8'hb0);
    rdat(d);
    chk_val({8'h00, d}, 16'h0000);
    $display("test wrap done");
  endtask

  task automatic t_dir;
    logic [7:0] d;
    cmd(8'h30);
    chk_val({9'h000, start}, 16'h0000);
    cmd(8'h18);
    chk_val({9'h000, start}, 16'h004f);
    cmd(8'h0c);
    chk_val({15'h0000, on}, 16'h0001);
    cmd(8'h04);
    cmd(8'h90);
    wdat(8'h11);
    ac_is(7'h0f);
    cmd(8'h06);
    wdat(8'h22);
    ac_is(7'h10);
    cmd(8'h01);
    chk_val({9'h000, start}, 16'h0000);
    rdat(d);
    chk_val({8'h00, d}, 16'h0020);
    ac_is(7'h01);
    cmd(8'h7f);
    wdat(8'h1e);
    ac_is(7'h00);
    cmd(8'h7f);
    rdat(d);
    chk_val({8'h00, d}, 16'h001e);
    $display("test direction done");
  endtask

  task automatic t_busy;
    logic [7:0] s;
    cmd(8'h90);
    u_host.xfer(1'b0, 1'b1, 8'h00, s);
    chk_val({15'h0000, s[7]}, 16'h0001);
    u_host.xfer(1'b0, 1'b0, 8'ha0, s);
    ac_is(7'h10);
    $display("test busy done");
  endtask

  // two nibbles per byte
  // A status poll would be a single nibble, so a fixed wait replaces it.
  task automatic x4(input logic rs4, input logic rw4, input logic [7:0] wd,
                    output logic [7:0] rd);
    logic [7:0] h;
    logic [7:0] l;
    u_host.xfer(rs4, rw4, {wd[7:4], 4'h0}, h);
    u_host.xfer(rs4, rw4, {wd[3:0], 4'h0}, l);
    rd = {h[7:4], l[7:4]};
    repeat (80) @(negedge mclk_i);
  endtask

  task automatic t_nibble;
    logic [7:0] r;
    cmd(8'h20);
    repeat (80) @(negedge mclk_i);
    x4(1'b0, 1'b0, 8'h85, r);
    x4(1'b1, 1'b0, 8'ha5, r);
    x4(1'b0, 1'b1, 8'h00, r);
    chk_val({8'h00, r}, 16'h0006);
    x4(1'b0, 1'b0, 8'h85, r);
    x4(1'b1, 1'b1, 8'h00, r);
    chk_val({8'h00, r}, 16'h00a5);
    x4(1'b0, 1'b0, 8'h30, r);
    ac_is(7'h06);
    $display("test nibble done");
  endtask

  // Codes 14h and 0ah keep the generated supply between 2.2 V and 6.5 V.
  task automatic t_supply;
    logic [7:0]  c [4] = '{8'h06, 8'hca, 8'h07, 8'h04};
    logic [10:0] x [4] = '{11'h004, 11'h454, 11'h254, 11'h4a5};
    cmd(8'h31);
    cmd(8'h94);
    chk_val({2'h0, {1'b0, sup.code} * 13'h050 + 13'h71c}, 16'h0d5c);
    chk_val({3'h0, sup.vop_mv}, 16'h0d5c);
    for (int i = 0; i < 4; i++)
    begin
      cmd(c[i]);
      chk_val({5'h00, sup.gen_on, sup.bypass, sup.code, sup.bias_levels},
              {5'h00, x[i]});
    end
    cmd(8'h34);
    chk_val({11'h000, sup.mux, sup.bias_levels},
            {11'h000, LHP_MUX_18, 3'h5});
    $display("test supply done");
  endtask

  task automatic t_frame;
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end while (tick !== 1'b1 && n < 4000);
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end while (tick !== 1'b1 && n < 4000);
    chk_val(16'(n), 16'h0c00);
    $display("test frame done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end

  initial
  begin
    resetn_i = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(negedge mclk_i);
    resetn_i = 1'b1;
    t_reset();
    t_wrap();
    t_dir();
    t_busy();
    t_nibble();
    t_supply();
    t_frame();
    end_sim();
  end
endmodule
